// ==== rtl/bps_service_port.sv ====
// Top of the four-lane backplane service port: lane paths, link-ready logic,
// register file and interrupt. Assumes a training engine on sys_clk supplies
// per-lane trained and signal-detect flags.
//
// Overview of operation
// - Four independent lanes 0..3, each with its own request and indication path.
// - Every lane streams continuously, one word each clock, both directions.
// - Link-ready means training finished on all four lanes, not energy present.
// - Link-ready takes exactly one of two values: OK or FAIL.
// - Link-ready is delivered upward as the signal-ok indication.
// - Transmit plus receive latency stays within 2048 bit times, 51.2 ns.
// - Transmit inter-lane skew under 54 ns, variation under 600 ps.
// - Receive skew delivered upward under 145 ns, variation under 3.6 ns.
// - Management control and status bits map onto internal variables.
// - Reset, or training restart while training is enabled, forces FAIL; all lanes trained gives OK.
// - Training disabled by management holds link-ready at OK.
// - Per-lane detect status bits follow each lane's training signal detect.
// - Transmit-off holds all transmitters constant; loopback stays unaffected.
`timescale 1ns/10ps
module bps_service_port #(
   parameter int WordW = 32 // Lane word width per clock
) (
   input wire logic sys_clk, // System clock, 250 MHz
   input wire logic resetn, // Async reset, active low
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] txReqData, // Words from above
   output logic [bps_pkg::NumLanes-1:0][WordW-1:0] rxIndData, // Words to above
   output logic [bps_pkg::NumLanes-1:0][WordW-1:0] txLineData, // Words to the line
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] rxLineData, // Words from the line
   output logic signalOk, // Link-ready indication, 1 = OK
   input wire logic [bps_pkg::NumLanes-1:0] laneTrained, // Lane training complete
   input wire logic [bps_pkg::NumLanes-1:0] laneDetect, // Lane signal detect
   output logic training_allow_bit, // Training enabled toward the engine
   output logic training_restart_bit, // One-cycle training restart pulse
   output logic irq, // Level interrupt
   input wire logic [bps_pkg::AddrW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [bps_pkg::DataW-1:0] s_axi_wdata, // Write data
   input wire logic [bps_pkg::DataW/8-1:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [bps_pkg::AddrW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [bps_pkg::DataW-1:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready // Read ready
);
   import bps_pkg::*;

   logic wrStb, rdStb, wrErr, rdErr;
   bps_wr_t wrReq;
   logic [AddrW-1:0] rdAddr;
   logic [DataW-1:0] rdData;

   bps_ctrl_t ctrl_r, ctrl_nxt;
   bps_link_t link_r, link_nxt;
   logic [NumLanes-1:0] trained_r, trained_nxt, detect_r, detect_nxt;
   logic [IrqW-1:0] irqStat_r, irqStat_nxt, irqMask_r, irqMask_nxt, irqEvt;
   logic irq_r, irq_nxt;
   logic global_link_ready_bit;
   logic all_lane_tx_off_bit;
   logic lane_zero_detect_bit;

   assign global_link_ready_bit = (link_r == BPS_OK);
   assign all_lane_tx_off_bit = ctrl_r.txOff;
   assign lane_zero_detect_bit = detect_r[0];
   assign signalOk = global_link_ready_bit;
   assign training_allow_bit = ctrl_r.allow;
   assign training_restart_bit = ctrl_r.restart;
   assign irq = irq_r;

   bps_axil_slave u_slave (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wrStb(wrStb),
      .wrReq(wrReq),
      .wrErr(wrErr),
      .rdStb(rdStb),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .rdErr(rdErr)
   );

   // Identical per-lane pipelines keep every lane at the same depth, so the
   // block adds no inter-lane skew and only a few cycles of latency.
   for (genvar ln = 0; ln < NumLanes; ln++) begin : g_lane
      bps_lane #(
         .WordW(WordW)
      ) u_lane (
         .sys_clk(sys_clk),
         .resetn(resetn),
         .txReqWord(txReqData[ln]),
         .rxLineWord(rxLineData[ln]),
         .txOff(all_lane_tx_off_bit),
         .loopback(ctrl_r.loopback),
         .txLineWord(txLineData[ln]),
         .rxIndWord(rxIndData[ln])
      );
   end

   // Register decode
   always_comb begin
      wrErr = 1'b0;
      if (wrReq.addr == CtrlAddr) begin
         wrErr = 1'b0;
      end else if (wrReq.addr == IrqMaskAddr) begin
         wrErr = 1'b0;
      end else if (wrReq.addr == StatusAddr || wrReq.addr == IrqStatAddr) begin
         wrErr = 1'b0;
      end else begin
         wrErr = 1'b1;
      end
   end

   always_comb begin
      rdData = '0;
      rdErr = 1'b0;
      if (rdAddr == CtrlAddr) begin
         rdData[CtrlAllowBit] = ctrl_r.allow;
         rdData[CtrlTxOffBit] = ctrl_r.txOff;
         rdData[CtrlLoopBit] = ctrl_r.loopback;
      end else if (rdAddr == StatusAddr) begin
         rdData[StatLinkBit] = global_link_ready_bit;
         rdData[StatDetLsb +: NumLanes] = detect_r;
         rdData[StatTrainLsb +: NumLanes] = trained_r;
      end else if (rdAddr == IrqStatAddr) begin
         rdData[IrqW-1:0] = irqStat_r;
      end else if (rdAddr == IrqMaskAddr) begin
         rdData[IrqW-1:0] = irqMask_r;
      end else begin
         rdErr = 1'b1;
      end
   end

   // Control register; restart is a self-clearing pulse
   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt.restart = 1'b0;
      irqMask_nxt = irqMask_r;
      if (wrStb && wrReq.strb[0]) begin
         if (wrReq.addr == CtrlAddr) begin
            ctrl_nxt.restart = wrReq.data[CtrlRestartBit];
            ctrl_nxt.allow = wrReq.data[CtrlAllowBit];
            ctrl_nxt.txOff = wrReq.data[CtrlTxOffBit];
            ctrl_nxt.loopback = wrReq.data[CtrlLoopBit];
         end else if (wrReq.addr == IrqMaskAddr) begin
            irqMask_nxt = wrReq.data[IrqW-1:0];
         end
      end
   end

   // Link-ready: two-valued, FAIL on reset or on restart while enabled, OK when all trained or disabled
   always_comb begin
      trained_nxt = laneTrained;
      detect_nxt = laneDetect;
      link_nxt = BPS_FAIL;
      if (!ctrl_r.allow) begin
         link_nxt = BPS_OK;
      end else if (ctrl_r.restart) begin
         link_nxt = BPS_FAIL;
      end else if (&trained_r) begin
         link_nxt = BPS_OK;
      end
   end

   // Sticky events; a read clears, a new event in the same cycle wins
   always_comb begin
      irqEvt = '0;
      irqEvt[IrqUpBit] = (link_r == BPS_FAIL) && (link_nxt == BPS_OK);
      irqEvt[IrqDownBit] = (link_r == BPS_OK) && (link_nxt == BPS_FAIL);
      irqStat_nxt = irqStat_r;
      if (rdStb && rdAddr == IrqStatAddr) begin
         irqStat_nxt = '0;
      end
      irqStat_nxt = irqStat_nxt | irqEvt;
      irq_nxt = |(irqStat_nxt & irqMask_nxt);
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= '{restart: CtrlReset[CtrlRestartBit], allow: CtrlReset[CtrlAllowBit],
            txOff: CtrlReset[CtrlTxOffBit], loopback: CtrlReset[CtrlLoopBit]};
         link_r <= BPS_FAIL;
         trained_r <= '0;
         detect_r <= '0;
         irqStat_r <= '0;
         irqMask_r <= '0;
         irq_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         link_r <= link_nxt;
         trained_r <= trained_nxt;
         detect_r <= detect_nxt;
         irqStat_r <= irqStat_nxt;
         irqMask_r <= irqMask_nxt;
         irq_r <= irq_nxt;
      end
   end
endmodule

// ==== rtl/bps_pkg.sv ====
// Package for the four-lane backplane service port: register map, fields, structs.
// Assumes a 250 MHz system clock and a 32-bit AXI4-Lite register bus.
package bps_pkg;
   localparam int NumLanes = 4;
   localparam int LaneIdxW = 2;
   localparam int LaneWordW = 32;
   localparam int AddrW = 8;
   localparam int DataW = 32;

   // Timing figures and their cycle counts
   localparam real ClkPeriodNs = 4.0;
   localparam real LineRateGBd = 10.3125;
   localparam real MaxLatencyNs = 51.2;
   localparam real MaxTxSkewNs = 54.0;
   localparam real MaxRxSkewNs = 145.0;
   localparam int MaxLatencyCyc = (int'($floor(MaxLatencyNs / ClkPeriodNs)) < 1) ? 1 :
      int'($floor(MaxLatencyNs / ClkPeriodNs));
   localparam int TxPathCyc = 1;
   localparam int RxPathCyc = 3;

   // Register byte addresses
   localparam logic [AddrW-1:0] CtrlAddr = 8'h00;
   localparam logic [AddrW-1:0] StatusAddr = 8'h04;
   localparam logic [AddrW-1:0] IrqStatAddr = 8'h08;
   localparam logic [AddrW-1:0] IrqMaskAddr = 8'h0C;

   // Control register fields
   localparam int CtrlRestartBit = 0;
   localparam int CtrlAllowBit = 1;
   localparam int CtrlTxOffBit = 2;
   localparam int CtrlLoopBit = 3;
   localparam logic [DataW-1:0] CtrlReset = 32'h0000_0002;

   // Status register fields
   localparam int StatLinkBit = 0;
   localparam int StatDetLsb = 1;
   localparam int StatTrainLsb = 5;

   // Interrupt events
   localparam int IrqW = 2;
   localparam int IrqUpBit = 0;
   localparam int IrqDownBit = 1;

   localparam logic [1:0] RespOkay = 2'h0;
   localparam logic [1:0] RespSlvErr = 2'h2;
   localparam logic [LaneWordW-1:0] TxIdleWord = 32'h0000_0000;

   typedef enum logic {BPS_FAIL, BPS_OK} bps_link_t;

   typedef struct packed {
      logic [AddrW-1:0] addr;
      logic [DataW-1:0] data;
      logic [DataW/8-1:0] strb;
   } bps_wr_t;

   typedef struct packed {
      logic restart;
      logic allow;
      logic txOff;
      logic loopback;
   } bps_ctrl_t;
endpackage

// ==== rtl/bps_axil_slave.sv ====
// AXI4-Lite slave front end: takes address and data in either order, one write
// and one read at a time. Assumes the register file answers combinationally.
`timescale 1ns/10ps
module bps_axil_slave
   import bps_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic [bps_pkg::AddrW-1:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [bps_pkg::DataW-1:0] s_axi_wdata, // Write data
   input wire logic [bps_pkg::DataW/8-1:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [bps_pkg::AddrW-1:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [bps_pkg::DataW-1:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   output logic wrStb, // Register write pulse
   output bps_pkg::bps_wr_t wrReq, // Register write request
   input wire logic wrErr, // Write address unmapped
   output logic rdStb, // Register read pulse
   output logic [bps_pkg::AddrW-1:0] rdAddr, // Register read address
   input wire logic [bps_pkg::DataW-1:0] rdData, // Register read data
   input wire logic rdErr // Read address unmapped
);
   import bps_pkg::*;
   logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, arHeld_r, arHeld_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [DataW-1:0] rdata_r, rdata_nxt;
   bps_wr_t wr_r, wr_nxt;
   logic [AddrW-1:0] ar_r, ar_nxt;

   assign wrStb = awHeld_r && wHeld_r && !bvalid_r;
   assign wrReq = wr_r;
   assign rdStb = arHeld_r && !rvalid_r;
   assign rdAddr = ar_r;
   assign s_axi_awready = !awHeld_r;
   assign s_axi_wready = !wHeld_r;
   assign s_axi_arready = !arHeld_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   always_comb begin
      awHeld_nxt = awHeld_r;
      wHeld_nxt = wHeld_r;
      arHeld_nxt = arHeld_r;
      bvalid_nxt = bvalid_r;
      rvalid_nxt = rvalid_r;
      bresp_nxt = bresp_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      wr_nxt = wr_r;
      ar_nxt = ar_r;
      if (s_axi_awvalid && !awHeld_r) begin
         awHeld_nxt = 1'b1;
         wr_nxt.addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !wHeld_r) begin
         wHeld_nxt = 1'b1;
         wr_nxt.data = s_axi_wdata;
         wr_nxt.strb = s_axi_wstrb;
      end
      if (wrStb) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = wrErr ? RespSlvErr : RespOkay;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
      end
      if (s_axi_arvalid && !arHeld_r) begin
         arHeld_nxt = 1'b1;
         ar_nxt = s_axi_araddr;
      end
      if (rdStb) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rdData;
         rresp_nxt = rdErr ? RespSlvErr : RespOkay;
      end
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
         arHeld_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         arHeld_r <= 1'b0;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         bresp_r <= RespOkay;
         rresp_r <= RespOkay;
         rdata_r <= '0;
         wr_r <= '0;
         ar_r <= '0;
      end else begin
         awHeld_r <= awHeld_nxt;
         wHeld_r <= wHeld_nxt;
         arHeld_r <= arHeld_nxt;
         bvalid_r <= bvalid_nxt;
         rvalid_r <= rvalid_nxt;
         bresp_r <= bresp_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
         wr_r <= wr_nxt;
         ar_r <= ar_nxt;
      end
   end
endmodule

// ==== rtl/bps_lane.sv ====
// One lane: transmit word register with disable hold, receive word through
// a two-stage synchroniser and output register, with a loopback tap.
`timescale 1ns/10ps
module bps_lane #(
   parameter int WordW = 32 // Lane word width
) (
   input wire logic sys_clk, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic [WordW-1:0] txReqWord, // Word requested from above
   input wire logic [WordW-1:0] rxLineWord, // Word from the receive line
   input wire logic txOff, // Hold the transmitter at a constant level
   input wire logic loopback, // Return transmit words to the receive side
   output logic [WordW-1:0] txLineWord, // Word toward the line
   output logic [WordW-1:0] rxIndWord // Word delivered upward
);
   logic [WordW-1:0] tx_r, tx_nxt, sync1_r, sync2_r, loop1_r, loop2_r, rx_r, rx_nxt;

   assign txLineWord = tx_r;
   assign rxIndWord = rx_r;

   always_comb begin
      // Constant level, no transitions, while disabled
      tx_nxt = txOff ? '0 : txReqWord;
      // Loopback path taps before the disable and keeps the same depth
      rx_nxt = loopback ? loop2_r : sync2_r;
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tx_r <= '0;
         sync1_r <= '0;
         sync2_r <= '0;
         loop1_r <= '0;
         loop2_r <= '0;
         rx_r <= '0;
      end else begin
         tx_r <= tx_nxt;
         sync1_r <= rxLineWord;
         sync2_r <= sync1_r;
         loop1_r <= txReqWord;
         loop2_r <= loop1_r;
         rx_r <= rx_nxt;
      end
   end
endmodule

// ==== verification/bps_service_port_props.sv ====
// Checker on the service port top: link-ready, lane paths and bus answer timing.
// Bound to every bps_service_port instance; one clock, resetn active low.
`timescale 1ns/10ps
module bps_service_port_props #(
   parameter int WordW = 32 // Lane word width
) (
   input wire logic sys_clk, // Clock
   input wire logic resetn, // Reset, active low
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] txReqData, // From above
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] rxIndData, // To above
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] txLineData, // To line
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] rxLineData, // From line
   input wire logic signalOk, // Link-ready
   input wire logic [bps_pkg::NumLanes-1:0] laneTrained, // Lane trained
   input wire logic training_allow_bit, // Training enabled
   input wire logic training_restart_bit, // Restart pulse
   input wire logic s_axi_awvalid, // Bus
   input wire logic s_axi_awready, // Bus
   input wire logic s_axi_wvalid, // Bus
   input wire logic s_axi_wready, // Bus
   input wire logic s_axi_bvalid, // Bus
   input wire logic s_axi_arvalid, // Bus
   input wire logic s_axi_arready, // Bus
   input wire logic s_axi_rvalid // Bus
);
   import bps_pkg::*;
   logic [2:0] upCnt_r;
   logic [2:0] upCnt_nxt;
   logic settled;
   // Pipelines hold reset values for a few edges after release
   always_comb begin
      upCnt_nxt = (upCnt_r == 3'h4) ? upCnt_r : upCnt_r + 3'h1;
      settled = (upCnt_r == 3'h4);
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         upCnt_r <= 3'h0;
      end else begin
         upCnt_r <= upCnt_nxt;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   AST_LINK_EQ: assert property (settled |-> signalOk == (!$past(training_allow_bit) ||
      (!$past(training_restart_bit) && &$past(laneTrained, 2))))
      else $error("link-ready not the registered lane AND");
   AST_NOT_TRAINED: assert property (training_allow_bit && !(&laneTrained) ##1
      training_allow_bit |=> !signalOk) else $error("link-ready OK before all lanes trained");
   AST_OFF_OK: assert property (!training_allow_bit |=> signalOk)
      else $error("link-ready not OK with training disabled");
   AST_RESTART_FAIL: assert property (training_restart_bit && training_allow_bit |=>
      !signalOk) else $error("restart did not force link-ready FAIL");
   AST_PULSE: assert property (training_restart_bit |=> !training_restart_bit [*2])
      else $error("restart pulse longer than one cycle");
   AST_TX_LANE: assert property (settled |-> txLineData == $past(txReqData) ||
      txLineData == '0) else $error("transmit lane word wrong");
   AST_RX_LANE: assert property (settled |-> rxIndData == $past(rxLineData, 3) ||
      rxIndData == $past(txReqData, 3)) else $error("receive lane word wrong");
   AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
   AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read data late");
endmodule

bind bps_service_port bps_service_port_props #(.WordW(WordW)) props_u (
   .sys_clk, .resetn, .txReqData, .rxIndData, .txLineData, .rxLineData, .signalOk,
   .laneTrained, .training_allow_bit, .training_restart_bit, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid
);

// ==== verification/bps_pma_model.sv ====
// Model of the attachment logic above: streams four lanes, watches link-ready.
// Assumes the device clock and an active-low reset.
`timescale 1ns/10ps
module bps_pma_model #(
   parameter int WordW = 32 // Lane word width
) (
   input wire logic sys_clk, // Clock
   input wire logic resetn, // Reset, active low
   input wire logic signalOk, // Link-ready from the device
   input wire logic [bps_pkg::NumLanes-1:0][WordW-1:0] rxIndData, // Words from device
   output logic [bps_pkg::NumLanes-1:0][WordW-1:0] txReqData, // Words to device
   output logic linkInd, // Link state toward negotiation
   output logic [15:0] goodWords // Words taken while link is OK
);
   import bps_pkg::*;
   logic [15:0] seq_r;
   logic [15:0] seq_nxt;
   logic [15:0] goodWords_r;
   logic [15:0] goodWords_nxt;
   always_comb begin
      seq_nxt = seq_r + 16'h0001;
      goodWords_nxt = signalOk ? goodWords_r + 16'h0001 : goodWords_r;
      for (int i = 0; i < NumLanes; i++) begin
         txReqData[i] = WordW'({8'(i), seq_r[7:0] ^ 8'hC3, seq_r});
      end
      linkInd = signalOk;
      goodWords = goodWords_r;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_r <= 16'h0000;
         goodWords_r <= 16'h0000;
      end else begin
         seq_r <= seq_nxt;
         goodWords_r <= goodWords_nxt;
      end
   end
endmodule

// ==== verification/tb_bps_service_port.sv ====
// Testbench for the service port: registers, link-ready, interrupt, lanes.
// Assumes the attachment model above and a line pattern made here.
`timescale 1ns/10ps
module tb_bps_service_port;
   import bps_pkg::*;
   typedef logic [NumLanes-1:0][31:0] bps_lanes_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [3:0] trn;
      logic [3:0] det;
      logic ok;
      logic [31:0] stat;
   } bps_row_t;
   localparam bps_row_t Rows [5] = '{
      '{32'h0000_0002, 4'hF, 4'hF, 1'b1, 32'h0000_01FF},
      '{32'h0000_0002, 4'h7, 4'h5, 1'b0, 32'h0000_00EA},
      '{32'h0000_0000, 4'h0, 4'hA, 1'b1, 32'h0000_0015},
      '{32'h0000_0002, 4'h8, 4'h1, 1'b0, 32'h0000_0102},
      '{32'h0000_0008, 4'hF, 4'h0, 1'b1, 32'h0000_01E1}};
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   bps_lanes_t txReqData, rxIndData, txLineData;
   bps_lanes_t rxLineData = '0;
   logic [3:0] laneTrained = 4'h0;
   logic [3:0] laneDetect = 4'h0;
   logic signalOk, training_allow_bit, training_restart_bit, irq, linkInd;
   logic [15:0] goodWords;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, okPrev = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, data;
   int fail_count = 0, check_count = 0, pulseCnt = 0, dropCnt = 0, cyc = 0, p, d;
   bps_lanes_t reqH [3];
   bps_lanes_t lineH [3];

   bps_service_port #(.WordW(32)) dut_u (
      .sys_clk, .resetn, .txReqData, .rxIndData, .txLineData, .rxLineData, .signalOk,
      .laneTrained, .laneDetect, .training_allow_bit, .training_restart_bit, .irq,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   bps_pma_model #(.WordW(32)) pma_u (.sys_clk, .resetn, .signalOk, .rxIndData,
      .txReqData, .linkInd, .goodWords);

   always #2 sys_clk = ~sys_clk;
   // Line pattern, history of both lane inputs, restart and link-drop counts
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < NumLanes; i++) rxLineData[i] <= {cyc[23:0] ^ 24'h5A_C3E1, 8'(i)};
      reqH <= '{txReqData, reqH[0], reqH[1]};
      lineH <= '{rxLineData, lineH[0], lineH[1]};
      pulseCnt <= pulseCnt + int'(training_restart_bit);
      dropCnt <= dropCnt + int'(okPrev && !signalOk);
      okPrev <= signalOk;
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (fail_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic tmo(inout int n);
      n++;
      if (n > 200) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic doReset();
      @(posedge sys_clk);
      resetn <= 1'b0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      idle(1);
   endtask
   task automatic setLanes(input logic [3:0] t, input logic [3:0] s);
      @(posedge sys_clk);
      laneTrained <= t;
      laneDetect <= s;
   endtask
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         tmo(n);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end while (s_axi_bready);
   endtask
   task automatic axiRead(input logic [7:0] a);
      int n = 0;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         tmo(n);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            resp = s_axi_rresp;
            data = s_axi_rdata;
            s_axi_rready <= 1'b0;
         end
      end while (s_axi_rready);
   endtask
   task automatic laneCheck(input logic lb, input logic off);
      idle(4);
      repeat (8) begin
         idle(1);
         check(txLineData, off ? {NumLanes{TxIdleWord}} : reqH[0]);
         check(rxIndData, lb ? reqH[2] : lineH[2]);
      end
   endtask

   initial begin
      doReset();
      check(128'({signalOk, training_allow_bit, irq}), 128'h2);
      axiRead(CtrlAddr);
      check(128'(data), 128'(CtrlReset));
      axiRead(IrqMaskAddr);
      check(128'(data), 128'h0);
      axiRead(8'h10);
      check(128'({resp, data}), 128'h2_0000_0000);
      axiWrite(8'h14, 32'h0000_0001);
      check(128'(resp), 128'h2);
      foreach (Rows[k]) begin
         setLanes(Rows[k].trn, Rows[k].det);
         axiWrite(CtrlAddr, Rows[k].ctrl);
         idle(4);
         check(128'(signalOk), 128'(Rows[k].ok));
         check(128'(training_allow_bit), 128'(Rows[k].ctrl[1]));
         axiRead(StatusAddr);
         check(128'(data), 128'(Rows[k].stat));
         axiRead(CtrlAddr);
         check(128'(data), 128'(Rows[k].ctrl));
      end
      // Restart with all lanes trained, then restart while training is disabled
      axiWrite(CtrlAddr, 32'h0000_0002);
      idle(4);
      p = pulseCnt;
      d = dropCnt;
      axiWrite(CtrlAddr, 32'h0000_0003);
      idle(4);
      check(128'({pulseCnt - p, dropCnt - d, signalOk}), 128'h2_0000_0003);
      axiWrite(CtrlAddr, 32'h0000_0001);
      idle(4);
      check(128'({dropCnt - d, signalOk}), 128'h3);
      // Interrupt raised on link loss, cleared by read, masked on link return
      axiWrite(IrqMaskAddr, 32'h0000_0003);
      axiWrite(CtrlAddr, 32'h0000_0002);
      axiRead(IrqStatAddr);
      idle(3);
      check(128'(irq), 128'h0);
      setLanes(4'h0, 4'h0);
      idle(4);
      check(128'(irq), 128'h1);
      axiRead(IrqStatAddr);
      check(128'(data), 128'h2);
      idle(3);
      check(128'(irq), 128'h0);
      axiWrite(IrqMaskAddr, 32'h0000_0002);
      setLanes(4'hF, 4'hF);
      idle(4);
      check(128'(irq), 128'h0);
      axiRead(IrqStatAddr);
      check(128'(data), 128'h1);
      // Lane paths: plain, transmit off, transmit off with loopback
      axiWrite(CtrlAddr, 32'h0000_0002);
      laneCheck(1'b0, 1'b0);
      axiWrite(CtrlAddr, 32'h0000_0006);
      laneCheck(1'b0, 1'b1);
      axiWrite(CtrlAddr, 32'h0000_000E);
      laneCheck(1'b1, 1'b1);
      doReset();
      check(128'({linkInd, signalOk, training_allow_bit}), 128'h1);
      axiRead(CtrlAddr);
      check(128'(data), 128'(CtrlReset));
      complete_run();
   end
endmodule
